// file: crate_cmd_cfg.svh
// constants of the crate packet command decoder
`ifndef CRATE_CMD_CFG_SVH
`define CRATE_CMD_CFG_SVH
// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define OP_DSP_WRITE_SAME 8'h00
`define OP_DSP_WRITE_DISTINCT 8'h01
`define OP_DSP_READ 8'h02
`define OP_CRATE_RESET 8'h0A
`define OP_NV_LOCK 8'h80
`define OP_NV_UNLOCK 8'h81
`define OP_NV_CLEAR 8'h82
`define OP_NV_WRITE 8'h83
`define OP_NV_READ 8'h84
`define OP_LUT_WRITE 8'h87
`define OP_DYN_MEM_CLEAR 8'h8C
`define OP_DYN_MEM_READ 8'h8F
`define OP_STATIC_MEM_CLEAR 8'h91
`define OP_STATIC_MEM_READ 8'h94
`define OP_NOP 8'hFF
// ----------------------------------------------------------------
// reply codes and flag bits
// ----------------------------------------------------------------
`define REPLY_OK 8'hC8
`define REPLY_FAULT 8'hC9
`define REPLY_TIMEOUT 8'hCA
`define NOTIFY_WARNING 8'hCB
`define REPLY_DIAGNOSTIC 8'hCC
`define FLAG_REPLY_REQUESTED 0
`define FLAG_BURST_WRITE 1
// ----------------------------------------------------------------
// register map, reset values, timing
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_CFG_ID_NEXT 8'h08
`define REG_CFG_ID_ACTIVE 8'h0C
`define REG_REPLY_COUNT 8'h10
`define CTRL_RESET 32'h0000_0001
`define CTRL_ENABLE_BIT 0
`define CFG_ID_BOOT 32'h0000_0001
`define CLK_MHZ 50
`define EXEC_TIMEOUT_US 100
`define EXEC_TIMEOUT_CYC (`EXEC_TIMEOUT_US * `CLK_MHZ)
`endif

// file: crate_cmd_pkg.sv
// types of the crate packet command decoder
package crate_cmd_pkg;
    typedef enum logic [3:0] {
        TGT_BAD = 4'h0, TGT_NOP = 4'h1, TGT_DSP_WR_SAME = 4'h2,
        TGT_DSP_WR_DISTINCT = 4'h3, TGT_DSP_RD = 4'h4, TGT_RESET = 4'h5,
        TGT_NV = 4'h6, TGT_LUT = 4'h7, TGT_DYN_MEM = 4'h8,
        TGT_STATIC_MEM = 4'h9
    } target_e;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_RT = 2'b10, ST_RT_SUSP = 2'b11
    } state_e;
    typedef struct packed {
        logic [7:0] first_dsp;
        logic [7:0] last_dsp;
        logic [7:0] opcode;
        logic [15:0] length;
        logic [7:0] flags;
        logic [7:0] cmd_id;
        logic [31:0] start_addr;
        logic diag;
    } cmd_hdr_s;
    typedef struct packed {
        target_e target;
        cmd_hdr_s hdr;
    } op_req_s;
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] cmd_id;
    } reply_s;
endpackage

// file: crate_packet_command_decoder.sv
// command decoder and real-time arbiter of the crate communication board
//
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "crate_cmd_cfg.svh"

module crate_packet_command_decoder
    import crate_cmd_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = `EXEC_TIMEOUT_CYC,
    parameter int unsigned CFG_ID_W = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // command input
    input wire logic cmd_valid_i,
    input wire cmd_hdr_s cmd_hdr_i,
    output logic cmd_ready_o,
    // ordinary command execution
    output logic op_start_o,
    output logic op_abort_o,
    output op_req_s op_o,
    input wire logic pkt_boundary_i,
    input wire logic op_done_i,
    input wire logic op_fault_i,
    // real-time transfers
    input wire logic rt_req_i,
    input wire logic sync_req_i,
    input wire logic rt_done_i,
    output logic rt_grant_o,
    // replies and notifications
    input wire logic warning_i,
    output logic reply_valid_o,
    output reply_s reply_o,
    // real-time frame tagging
    input wire logic cfg_apply_i,
    input wire logic frame_valid_i,
    output logic frame_tag_valid_o,
    output logic [CFG_ID_W-1:0] frame_cfg_id_o
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic target_e decode_target(input logic [7:0] op);
        if (op == `OP_DSP_WRITE_SAME) decode_target = TGT_DSP_WR_SAME;
        else if (op == `OP_DSP_WRITE_DISTINCT)
            decode_target = TGT_DSP_WR_DISTINCT;
        else if (op == `OP_DSP_READ) decode_target = TGT_DSP_RD;
        else if (op == `OP_CRATE_RESET) decode_target = TGT_RESET;
        else if (op >= `OP_NV_LOCK && op <= `OP_NV_READ)
            decode_target = TGT_NV;
        else if (op == `OP_LUT_WRITE) decode_target = TGT_LUT;
        else if (op >= `OP_DYN_MEM_CLEAR && op <= `OP_DYN_MEM_READ)
            decode_target = TGT_DYN_MEM;
        else if (op >= `OP_STATIC_MEM_CLEAR && op <= `OP_STATIC_MEM_READ)
            decode_target = TGT_STATIC_MEM;
        else if (op == `OP_NOP) decode_target = TGT_NOP;
        else decode_target = TGT_BAD;
    endfunction

    function automatic logic is_read(input logic [7:0] op);
        is_read = (op == `OP_DSP_READ) | (op == `OP_NV_READ)
            | (op == `OP_DYN_MEM_READ) | (op == `OP_STATIC_MEM_READ);
    endfunction

    function automatic logic [31:0] merge_bytes(input logic [31:0] old,
        input logic [31:0] wdat, input logic [3:0] sel);
        merge_bytes = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) merge_bytes[8*i +: 8] = wdat[8*i +: 8];
        end
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    state_e state, next_state;
    cmd_hdr_s cur;
    logic [31:0] ctrl, cfg_next, reply_count, timer;
    logic [CFG_ID_W-1:0] cfg_active;
    logic warn_pend;
    logic next_reply_valid;
    reply_s next_reply;

    wire rt_any = rt_req_i | sync_req_i;
    wire enabled = ctrl[`CTRL_ENABLE_BIT];
    wire accept = cmd_valid_i & cmd_ready_o & ~rt_any;
    wire target_e in_tgt = decode_target(cmd_hdr_i.opcode);
    wire range_bad = cmd_hdr_i.first_dsp > cmd_hdr_i.last_dsp;
    wire in_bad = (in_tgt == TGT_BAD) | range_bad;
    wire in_read = is_read(cmd_hdr_i.opcode);
    wire in_want = cmd_hdr_i.flags[`FLAG_REPLY_REQUESTED] | in_read;
    // reads always answer, so a host that forgets the flag still gets data
    wire cur_want = cur.flags[`FLAG_REPLY_REQUESTED]
        | is_read(cur.opcode);
    wire in_launch = accept & ~cmd_hdr_i.diag & ~in_bad
        & (in_tgt != TGT_NOP);
    wire timeout_hit = (timer == 32'(TIMEOUT_CYC - 1));

    // ----------------------------------------------------------------
    // arbiter and reply selection
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_reply_valid = 1'b0;
        next_reply = '{code: `REPLY_OK, cmd_id: cur.cmd_id};
        case (state)
            ST_IDLE: begin
                if (rt_any) begin
                    next_state = ST_RT;
                end else if (accept) begin
                    next_reply.cmd_id = cmd_hdr_i.cmd_id;
                    if (cmd_hdr_i.diag) begin
                        next_reply_valid = 1'b1;
                        next_reply.code = `REPLY_DIAGNOSTIC;
                    end else if (in_bad) begin
                        next_reply_valid = 1'b1;
                        next_reply.code = `REPLY_FAULT;
                    end else if (in_tgt == TGT_NOP) begin
                        next_reply_valid = in_want;
                    end else begin
                        next_state = ST_EXEC;
                    end
                end
            end
            ST_EXEC: begin
                if (op_done_i) begin
                    next_state = ST_IDLE;
                    next_reply_valid = cur_want | op_fault_i;
                    next_reply.code = op_fault_i ? `REPLY_FAULT
                                                 : `REPLY_OK;
                end else if (timeout_hit) begin
                    next_state = ST_IDLE;
                    next_reply_valid = 1'b1;
                    next_reply.code = `REPLY_TIMEOUT;
                end else if (rt_any & pkt_boundary_i) begin
                    next_state = ST_RT_SUSP;
                end
            end
            ST_RT: begin
                if (rt_done_i) next_state = ST_IDLE;
            end
            ST_RT_SUSP: begin
                if (rt_done_i) next_state = ST_EXEC;
            end
            default: next_state = ST_IDLE;
        endcase
        // a warning only goes out in a cycle with no command reply
        if (!next_reply_valid && warn_pend) begin
            next_reply_valid = 1'b1;
            next_reply = '{code: `NOTIFY_WARNING, cmd_id: 8'h00};
        end
    end

    wire warn_sent = warn_pend & next_reply_valid
        & (next_reply.code == `NOTIFY_WARNING);

    // ----------------------------------------------------------------
    // control flops
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            cur <= '0;
            timer <= '0;
            warn_pend <= 1'b0;
            cmd_ready_o <= 1'b0;
            op_start_o <= 1'b0;
            op_abort_o <= 1'b0;
            op_o <= '0;
            rt_grant_o <= 1'b0;
            reply_valid_o <= 1'b0;
            reply_o <= '0;
        end else begin
            state <= next_state;
            if (accept) cur <= cmd_hdr_i;
            if (in_launch | (state == ST_IDLE)) timer <= '0;
            else if (state == ST_EXEC) timer <= timer + 32'h0000_0001;
            // a new warning wins over the one being sent
            warn_pend <= warning_i | (warn_pend & ~warn_sent);
            cmd_ready_o <= (next_state == ST_IDLE) & enabled;
            op_start_o <= in_launch;
            op_abort_o <= (state == ST_EXEC) & ~op_done_i & timeout_hit;
            if (in_launch) begin
                op_o.target <= in_tgt;
                op_o.hdr <= cmd_hdr_i;
            end
            rt_grant_o <= (next_state == ST_RT)
                | (next_state == ST_RT_SUSP);
            reply_valid_o <= next_reply_valid;
            reply_o <= next_reply;
        end
    end

    // ----------------------------------------------------------------
    // configuration identifier and frame tags
    // ----------------------------------------------------------------
    // software stages the next identifier; it only becomes the one in use
    // when the datapath really switches, so frames never carry a guess
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_active <= CFG_ID_W'(`CFG_ID_BOOT);
            frame_tag_valid_o <= 1'b0;
            frame_cfg_id_o <= '0;
        end else begin
            if (cfg_apply_i) cfg_active <= cfg_next[CFG_ID_W-1:0];
            frame_tag_valid_o <= frame_valid_i;
            if (frame_valid_i) frame_cfg_id_o <= cfg_active;
        end
    end

    // ----------------------------------------------------------------
    // wishbone slave
    // ----------------------------------------------------------------
    wire wb_req = wb_cyc_i & wb_stb_i;
    wire wb_wr = wb_req & wb_we_i & wb_ack_o;
    wire [31:0] status_word = {28'h000_0000, warn_pend, rt_grant_o,
        2'(state)};
    wire [31:0] rd_mux =
        (wb_adr_i == `REG_CTRL) ? ctrl :
        (wb_adr_i == `REG_STATUS) ? status_word :
        (wb_adr_i == `REG_CFG_ID_NEXT) ? cfg_next :
        (wb_adr_i == `REG_CFG_ID_ACTIVE) ? 32'(cfg_active) :
        (wb_adr_i == `REG_REPLY_COUNT) ? reply_count : 32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= `CTRL_RESET;
            cfg_next <= `CFG_ID_BOOT;
            reply_count <= '0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_req & ~wb_ack_o;
            if (wb_req & ~wb_ack_o) wb_dat_o <= rd_mux;
            if (wb_wr && wb_adr_i == `REG_CTRL) begin
                ctrl <= merge_bytes(ctrl, wb_dat_i, wb_sel_i);
            end else if (wb_wr && wb_adr_i == `REG_CFG_ID_NEXT) begin
                cfg_next <= merge_bytes(cfg_next, wb_dat_i, wb_sel_i);
            end
            if (next_reply_valid) reply_count <= reply_count + 32'h0000_0001;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_rt_first;
        @(posedge clk_i) disable iff (rst_i)
        (state == ST_IDLE && rt_any) |=> rt_grant_o && !op_start_o;
    endproperty
    a_rt_first: assert property (p_rt_first)
        else $error("ordinary command started ahead of real time");

    property p_rt_boundary;
        @(posedge clk_i) disable iff (rst_i)
        (state == ST_EXEC && rt_any && pkt_boundary_i && !op_done_i
            && !timeout_hit) |=> rt_grant_o && state == ST_RT_SUSP;
    endproperty
    a_rt_boundary: assert property (p_rt_boundary)
        else $error("real time not inserted at packet boundary");

    property p_sync;
        @(posedge clk_i) disable iff (rst_i)
        sync_req_i && (state == ST_IDLE || (state == ST_EXEC
            && pkt_boundary_i && !op_done_i && !timeout_hit))
            |=> rt_grant_o;
    endproperty
    a_sync: assert property (p_sync)
        else $error("sync transfer not granted real time priority");

    property p_cfg_boot;
        @(posedge clk_i) disable iff (rst_i)
        $past(rst_i) |-> cfg_active == CFG_ID_W'(`CFG_ID_BOOT);
    endproperty
    a_cfg_boot: assert property (p_cfg_boot)
        else $error("boot configuration identifier is not one");

    property p_tag;
        @(posedge clk_i) disable iff (rst_i)
        frame_valid_i |=> frame_tag_valid_o
            && frame_cfg_id_o == $past(cfg_active);
    endproperty
    a_tag: assert property (p_tag)
        else $error("frame tagged with wrong configuration identifier");

    property p_bad;
        @(posedge clk_i) disable iff (rst_i)
        (accept && !cmd_hdr_i.diag && in_bad) |=> reply_valid_o
            && reply_o.code == `REPLY_FAULT && !op_start_o
            && reply_o.cmd_id == $past(cmd_hdr_i.cmd_id);
    endproperty
    a_bad: assert property (p_bad)
        else $error("bad command not answered with fault");

    property p_timeout;
        @(posedge clk_i) disable iff (rst_i)
        (state == ST_EXEC && timeout_hit && !op_done_i) |=> reply_valid_o
            && reply_o.code == `REPLY_TIMEOUT && op_abort_o;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("execution timeout not reported");

    property p_ok;
        @(posedge clk_i) disable iff (rst_i)
        (state == ST_EXEC && op_done_i && !op_fault_i && cur_want)
            |=> reply_valid_o && reply_o.code == `REPLY_OK
            && reply_o.cmd_id == $past(cur.cmd_id);
    endproperty
    a_ok: assert property (p_ok)
        else $error("successful command not answered with success");

    property p_warn;
        @(posedge clk_i) disable iff (rst_i)
        (warning_i && state == ST_IDLE && !cmd_valid_i && !rt_any)
            ##1 !cmd_valid_i
            |=> reply_valid_o && reply_o.code == `NOTIFY_WARNING;
    endproperty
    a_warn: assert property (p_warn)
        else $error("warning not notified");
endmodule // crate_packet_command_decoder
`default_nettype wire

// file: crate_packet_command_decoder_tb_top.sv
// self-checking testbench of the crate packet command decoder
`timescale 1ns/1ps
`default_nettype none
`include "crate_cmd_cfg.svh"
module crate_packet_command_decoder_tb_top
    import crate_cmd_pkg::*;
;
    // ------------------------------------------------------------
    // harness
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
        target_e tgt;
    } row_s;
    row_s rows [8] = '{
        '{8'h00, 8'h00, TGT_DSP_WR_SAME},
        '{8'h01, 8'h01, TGT_DSP_WR_DISTINCT},
        '{8'h02, 8'h02, TGT_DSP_RD},
        '{8'h0A, 8'h0A, TGT_RESET},
        '{8'h80, 8'h84, TGT_NV},
        '{8'h87, 8'h87, TGT_LUT},
        '{8'h8C, 8'h8F, TGT_DYN_MEM},
        '{8'h91, 8'h94, TGT_STATIC_MEM}
    };
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0000_0000, wb_dat_o;
    logic cmd_valid = 1'b0, rt_req = 1'b0, sync_req = 1'b0;
    logic rt_done = 1'b0, warning = 1'b0, cfg_apply = 1'b0;
    logic frame_valid = 1'b0, fault_m = 1'b0, hang = 1'b0;
    logic [7:0] len = 8'h0A;
    cmd_hdr_s cmd_hdr = '0;
    logic wb_ack_o, cmd_ready_o, op_start_o, op_abort_o, rt_grant_o;
    logic reply_valid_o, frame_tag_valid_o, bnd, done, flt;
    op_req_s op_o;
    reply_s reply_o;
    logic [15:0] frame_cfg_id_o;
    logic [7:0] rep_code, rep_id;
    int n_errors = 0, check_count = 0, n_rep = 0, n_start = 0;
    int n_abort = 0;

    always #10 clk_i = ~clk_i;

    crate_packet_command_decoder #(.TIMEOUT_CYC(20), .CFG_ID_W(16)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .cmd_valid_i(cmd_valid), .cmd_hdr_i(cmd_hdr),
        .cmd_ready_o(cmd_ready_o), .op_start_o(op_start_o),
        .op_abort_o(op_abort_o), .op_o(op_o), .pkt_boundary_i(bnd),
        .op_done_i(done), .op_fault_i(flt), .rt_req_i(rt_req),
        .sync_req_i(sync_req), .rt_done_i(rt_done),
        .rt_grant_o(rt_grant_o), .warning_i(warning),
        .reply_valid_o(reply_valid_o), .reply_o(reply_o),
        .cfg_apply_i(cfg_apply), .frame_valid_i(frame_valid),
        .frame_tag_valid_o(frame_tag_valid_o),
        .frame_cfg_id_o(frame_cfg_id_o));

    op_exec_model model (
        .clk_i(clk_i), .rst_i(rst_i), .start_i(op_start_o),
        .abort_i(op_abort_o), .grant_i(rt_grant_o), .len_i(len),
        .fault_i(fault_m), .hang_i(hang), .boundary_o(bnd),
        .done_o(done), .fault_o(flt));

    always @(posedge clk_i) begin
        if (reply_valid_o === 1'b1) begin
            n_rep <= n_rep + 1;
            rep_code <= reply_o.code;
            rep_id <= reply_o.cmd_id;
        end
        if (op_start_o === 1'b1)
            n_start <= n_start + 1;
        if (op_abort_o === 1'b1)
            n_abort <= n_abort + 1;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (n_errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // request held until ack is sampled high, released on that edge
    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat <= d;
        do
            @(posedge clk_i);
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, adr, 32'h0000_0000, q);
        chk(q, exp);
    endtask

    // sr: launch expected, reply expected
    task automatic run_cmd(input logic [7:0] op, input logic [7:0] fl,
                           input logic dg, input logic [15:0] rng,
                           input logic [1:0] sr, input logic [7:0] code,
                           input target_e tgt);
        int s0, r0;
        logic [7:0] id;
        s0 = n_start;
        r0 = n_rep;
        id = op ^ 8'h5A;
        @(posedge clk_i);
        cmd_hdr <= '{rng[15:8], rng[7:0], op, 16'h0010, fl, id,
                     32'h0000_1000, dg};
        cmd_valid <= 1'b1;
        // taken at the edge that samples ready with no real time pending
        do
            @(posedge clk_i);
        while (!(cmd_ready_o === 1'b1 && rt_req === 1'b0
                 && sync_req === 1'b0));
        cmd_valid <= 1'b0;
        // leave one edge after ready rises, where the counter takes the reply
        do
            @(posedge clk_i);
        while (cmd_ready_o !== 1'b1);
        @(negedge clk_i);
        chk(n_start - s0, sr[1]);
        chk(n_rep - r0, sr[0]);
        if (sr[0]) begin
            chk({rep_code, rep_id}, {code, id});
        end
        if (sr[1]) begin
            chk(op_o.target, tgt);
            chk({op_o.hdr.opcode, op_o.hdr.flags}, {op, fl});
        end
    endtask

    task automatic frame(input logic [15:0] id);
        @(posedge clk_i);
        frame_valid <= 1'b1;
        @(posedge clk_i);
        frame_valid <= 1'b0;
        @(negedge clk_i);
        chk(frame_tag_valid_o, 1'b1);
        chk(frame_cfg_id_o, id);
    endtask

    initial begin
        #(20 * 20000);
        n_errors++;
        conclude();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        int s;
        logic [31:0] q;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk(cmd_ready_o, 1'b0);
        repeat (3) @(negedge clk_i);
        chk(cmd_ready_o, 1'b1);
        rd(`REG_CTRL, `CTRL_RESET);
        rd(`REG_CFG_ID_NEXT, `CFG_ID_BOOT);
        rd(`REG_CFG_ID_ACTIVE, `CFG_ID_BOOT);
        wb(1'b1, 8'h40, 32'hFFFF_FFFF, q);
        rd(8'h40, 32'h0000_0000);
        wb(1'b1, `REG_CFG_ID_ACTIVE, 32'h0000_0077, q);
        rd(`REG_CFG_ID_ACTIVE, `CFG_ID_BOOT);
        for (int i = 0; i < 8; i++)
            for (int op = rows[i].lo; op <= rows[i].hi; op++)
                run_cmd(8'(op), 8'h01, 1'b0, 16'h0205, 2'b11,
                        `REPLY_OK, rows[i].tgt);
        run_cmd(8'h01, 8'h03, 1'b0, 16'h0003, 2'b11, `REPLY_OK,
                TGT_DSP_WR_DISTINCT);
        run_cmd(8'h83, 8'h00, 1'b0, 16'h0303, 2'b10, 8'h00, TGT_NV);
        run_cmd(8'h94, 8'h00, 1'b0, 16'h0303, 2'b11, `REPLY_OK,
                TGT_STATIC_MEM);
        run_cmd(8'h02, 8'h01, 1'b0, 16'h0602, 2'b01, `REPLY_FAULT,
                TGT_BAD);
        run_cmd(8'h0C, 8'h01, 1'b0, 16'h0000, 2'b01, `REPLY_FAULT,
                TGT_BAD);
        run_cmd(8'h85, 8'h01, 1'b0, 16'h0000, 2'b01, `REPLY_FAULT,
                TGT_BAD);
        run_cmd(8'hFF, 8'h01, 1'b0, 16'h0000, 2'b01, `REPLY_OK,
                TGT_BAD);
        run_cmd(8'hFF, 8'h00, 1'b0, 16'h0000, 2'b00, 8'h00, TGT_BAD);
        run_cmd(8'h02, 8'h01, 1'b1, 16'h0000, 2'b01, `REPLY_DIAGNOSTIC,
                TGT_BAD);
        fault_m <= 1'b1;
        run_cmd(8'h8C, 8'h01, 1'b0, 16'h0000, 2'b11, `REPLY_FAULT,
                TGT_DYN_MEM);
        fault_m <= 1'b0;
        hang <= 1'b1;
        s = n_abort;
        run_cmd(8'h82, 8'h01, 1'b0, 16'h0000, 2'b11, `REPLY_TIMEOUT,
                TGT_NV);
        chk(n_abort - s, 1);
        hang <= 1'b0;
        @(posedge clk_i);
        warning <= 1'b1;
        @(posedge clk_i);
        warning <= 1'b0;
        // one edge sets the pending flag, the next sends the notice
        repeat (2) @(negedge clk_i);
        chk(reply_valid_o, 1'b1);
        chk({reply_o.code, reply_o.cmd_id}, {`NOTIFY_WARNING, 8'h00});
        wb(1'b1, `REG_CTRL, 32'h0000_0000, q);
        repeat (2) @(negedge clk_i);
        chk(cmd_ready_o, 1'b0);
        wb(1'b1, `REG_CTRL, 32'h0000_0001, q);
        // real time pending in idle blocks a waiting command
        @(posedge clk_i);
        rt_req <= 1'b1;
        s = n_start;
        fork
            run_cmd(8'h87, 8'h01, 1'b0, 16'h0000, 2'b11, `REPLY_OK, TGT_LUT);
            begin
                repeat (3) @(negedge clk_i);
                chk(rt_grant_o, 1'b1);
                repeat (6) @(negedge clk_i);
                chk(n_start - s, 0);
                rd(`REG_STATUS, 32'h0000_0006);
                @(posedge clk_i);
                rt_done <= 1'b1;
                rt_req <= 1'b0;
                @(posedge clk_i);
                rt_done <= 1'b0;
                @(negedge clk_i);
                chk(rt_grant_o, 1'b0);
            end
        join
        // sync request during a running command waits for a boundary
        len <= 8'h0E;
        s = n_start;
        fork
            run_cmd(8'h00, 8'h01, 1'b0, 16'h0000, 2'b11, `REPLY_OK,
                    TGT_DSP_WR_SAME);
            begin
                wait (n_start != s);
                @(posedge clk_i);
                sync_req <= 1'b1;
                for (int k = 0; k < 40; k++) begin
                    @(negedge clk_i);
                    if (bnd === 1'b1)
                        break;
                    chk(rt_grant_o, 1'b0);
                end
                @(negedge clk_i);
                chk(rt_grant_o, 1'b1);
                repeat (4) @(posedge clk_i);
                rt_done <= 1'b1;
                sync_req <= 1'b0;
                @(posedge clk_i);
                rt_done <= 1'b0;
            end
        join
        len <= 8'h0A;
        wb(1'b1, `REG_CFG_ID_NEXT, 32'h0000_0002, q);
        frame(16'h0001);
        @(posedge clk_i);
        cfg_apply <= 1'b1;
        @(posedge clk_i);
        cfg_apply <= 1'b0;
        frame(16'h0002);
        rd(`REG_CFG_ID_ACTIVE, 32'h0000_0002);
        rd(`REG_REPLY_COUNT, 32'h0000_001E);
        conclude();
    end
endmodule // crate_packet_command_decoder_tb_top
`default_nettype wire

// file: op_exec_model.sv
// execution-side partner model of the crate packet command decoder
`timescale 1ns/1ps
`default_nettype none
module op_exec_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // launch, abort and real-time grant from the decoder
    input wire logic start_i,
    input wire logic abort_i,
    input wire logic grant_i,
    // behaviour chosen by the bench
    input wire logic [7:0] len_i,
    input wire logic fault_i,
    input wire logic hang_i,
    // completion towards the decoder
    output logic boundary_o,
    output logic done_o,
    output logic fault_o
);
    // ------------------------------------------------------------
    // packet and completion sequencing
    // ------------------------------------------------------------
    logic busy;
    logic [7:0] cnt;
    // frozen while real time owns the link, as the transport would be
    always_ff @(posedge clk_i) begin
        boundary_o <= 1'b0;
        done_o <= 1'b0;
        // fault means nothing outside done, so keep it moving
        fault_o <= ~fault_o;
        if (rst_i || abort_i) begin
            busy <= 1'b0;
            cnt <= 8'h00;
            fault_o <= 1'b0;
        end else if (start_i) begin
            busy <= 1'b1;
            cnt <= 8'h01;
        end else if (busy && !grant_i) begin
            cnt <= cnt + 8'h01;
            boundary_o <= (cnt[1:0] == 2'b11);
            if (cnt == len_i && !hang_i) begin
                done_o <= 1'b1;
                fault_o <= fault_i;
                busy <= 1'b0;
            end
        end
    end
endmodule // op_exec_model
`default_nettype wire
